// file: operand_address_generator_defs.vh
// constants for the operand address generator
// assumes a 16-bit byte-addressed core with a workspace pointer in memory
`ifndef OPERAND_ADDRESS_GENERATOR_DEFS_VH
`define OPERAND_ADDRESS_GENERATOR_DEFS_VH
`define MODE_DIRECT 2'h0
`define MODE_INDIRECT 2'h1
`define MODE_SYMBOLIC 2'h2
`define MODE_AUTOINC 2'h3
`define REG_ZERO 4'h0
`define BYTE_STEP 16'h0001
`define WORD_STEP 16'h0002
`define ZERO16 16'h0000
`define FMT_TWO_OP 3'h0
`define FMT_IMMEDIATE 3'h1
`define FMT_JUMP 3'h2
`define FMT_NONE 3'h3
`define IMM_APPLY 2'h0
`define IMM_LOAD_WP 2'h1
`define IMM_LOAD_MASK 2'h2
`define JCOND_ALWAYS 1'h0
`define JCOND_EQUAL 1'h1
`define EQ_BIT 2
`define MASK_LSB 12
`define FLD_BYTE 12
`define FLD_DMODE 11:10
`define FLD_DREG 9:6
`define FLD_SMODE 5:4
`define FLD_SREG 3:0
`define FLD_DISP 7:0
`endif

// file: operand_address_generator.v
// operand effective-address generator: decodes one instruction word
// assumes a memory port answering one read or write per request with mem_ack
// Function
// RL1 - indirect mode: register contents address the operand
// RL2 - autoincrement adds one for byte, two word
// RL3 - words two address units apart, bytes one
// RL4 - symbolic, register zero: next word is address
// RL5 - symbolic address is full 16-bit extension word
// RL6 - first extension is source, second is destination
// RL7 - symbolic nonzero register field selects indexing
// RL8 - indexed address is extension plus index register
// RL9 - register zero never serves as index
// RL10 - only symbolic mode ever adds an index
// RL11 - pointers come only from workspace registers
// RL12 - immediate taken from stream, applied or loaded
// RL13 - relative jumps unconditional or on status test
// RL14 - jump if equal only when equal flag set
// RL15 - jump offset in bytes from jump address; code doubles the 8-bit offset, so the offset counts words
// RL16 - mode zero: operand is register itself
// RL17 - byte flag set means byte operand
// RL18 - two-operand field positions as listed
// RL19 - autoincrement written back after address use
`timescale 1ns/1ps
`include "operand_address_generator_defs.vh"
module operand_address_generator #(
   parameter W = 16
) (
   input wire clk,
   input wire rst_n,
   input wire start,
   input wire [W-1:0] instr,
   input wire [2:0] fmt,
   input wire [1:0] imm_kind,
   input wire jump_cond,
   input wire [W-1:0] pc,
   input wire [W-1:0] wp,
   input wire [W-1:0] status_word,
   output reg mem_req,
   output reg mem_we,
   output reg [W-1:0] mem_addr,
   output reg [W-1:0] mem_wdata,
   input wire mem_ack,
   input wire [W-1:0] mem_rdata,
   output reg busy,
   output reg done,
   output reg src_is_reg,
   output reg [W-1:0] src_ea,
   output reg dst_is_reg,
   output reg [W-1:0] dst_ea,
   output reg byte_op,
   output reg [W-1:0] imm_value,
   output reg imm_valid,
   output reg load_wp,
   output reg load_mask,
   output reg [W-1:0] next_pc,
   output reg jump_taken
);
   // ***************************************
   // reset release
   // ***************************************
   // release is synchronous so no flop leaves reset a cycle early
   reg rst_s1_r, rst_s2_r;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   wire rstn_i = rst_s2_r;

   // ***************************************
   // helpers
   // ***************************************
   // wraps at the top of memory, as the address space does
   // workspace register n sits at wp + 2n (word spacing)
   function [W-1:0] reg_addr;
      input [W-1:0] base;
      input [3:0] n;
      begin
         reg_addr = base + {{(W-5){1'b0}}, n, 1'b0}; // see RL3
      end
   endfunction

   localparam S_IDLE = 4'h0, S_SRC_PTR = 4'h1, S_SRC_EXT = 4'h2, S_SRC_IDX = 4'h3,
      S_SRC_INC = 4'h4, S_DST_PTR = 4'h5, S_DST_EXT = 4'h6, S_DST_IDX = 4'h7,
      S_DST_INC = 4'h8, S_IMM = 4'h9, S_DONE = 4'ha;

   reg [3:0] state_r;
   reg [W-1:0] ipc_r, ins_r, ptr_r;

   // see RL18: fields numbered with bit 0 as lsb
   wire [1:0] dest_mode_field = ins_r[`FLD_DMODE];
   wire [3:0] dest_reg_field = ins_r[`FLD_DREG];
   wire [1:0] src_mode_field = ins_r[`FLD_SMODE];
   wire [3:0] src_reg_field = ins_r[`FLD_SREG];
   wire byte_flag = ins_r[`FLD_BYTE]; // see RL17
   wire [W-1:0] step = byte_flag ? `BYTE_STEP : `WORD_STEP; // see RL2 RL3
   wire [7:0] disp = instr[`FLD_DISP];
   wire [W-1:0] disp_bytes = {{(W-9){disp[7]}}, disp, 1'b0};

   // ***************************************
   // fields of the word offered with start
   // ***************************************
   // decoded live so the first access leaves in the take cycle
   wire in_byte = instr[`FLD_BYTE];
   wire [1:0] in_dmode = instr[`FLD_DMODE];
   wire [3:0] in_dreg = instr[`FLD_DREG];
   wire [1:0] in_smode = instr[`FLD_SMODE];
   wire [3:0] in_sreg = instr[`FLD_SREG];

   // mode to first state for a given operand side
   function [3:0] first_state;
      input [1:0] mode;
      input [3:0] rf;
      input dst;
      begin
         case (mode)
            `MODE_INDIRECT, `MODE_AUTOINC: first_state = dst ? S_DST_PTR : S_SRC_PTR; // see RL1 RL11
            `MODE_SYMBOLIC: first_state = dst ? S_DST_EXT : S_SRC_EXT; // see RL4 RL5
            default: first_state = dst ? S_DONE : S_DST_PTR;
         endcase
      end
   endfunction

   wire [3:0] after_src = (dest_mode_field == `MODE_DIRECT) ? S_DONE : first_state(dest_mode_field, dest_reg_field, 1'b1);

   // ***************************************
   // sequencer
   // ***************************************
   always @(posedge clk or negedge rstn_i) begin
      if (!rstn_i) begin
         state_r <= S_IDLE;
         ipc_r <= `ZERO16;
         ins_r <= `ZERO16;
         ptr_r <= `ZERO16;
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= `ZERO16;
         mem_wdata <= `ZERO16;
         busy <= 1'b0;
         done <= 1'b0;
         src_is_reg <= 1'b0;
         src_ea <= `ZERO16;
         dst_is_reg <= 1'b0;
         dst_ea <= `ZERO16;
         byte_op <= 1'b0;
         imm_value <= `ZERO16;
         imm_valid <= 1'b0;
         load_wp <= 1'b0;
         load_mask <= 1'b0;
         next_pc <= `ZERO16;
         jump_taken <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state_r)
            S_IDLE: begin
               if (start) begin
                  busy <= 1'b1;
                  ins_r <= instr;
                  ipc_r <= pc + `WORD_STEP;
                  imm_valid <= 1'b0;
                  load_wp <= 1'b0;
                  load_mask <= 1'b0;
                  jump_taken <= 1'b0;
                  byte_op <= in_byte;
                  case (fmt)
                     `FMT_JUMP: begin
                        // see RL13 RL14: equal test on status bit
                        if (jump_cond == `JCOND_ALWAYS || status_word[W-1-`EQ_BIT]) begin
                           next_pc <= pc + disp_bytes; // see RL15
                           jump_taken <= 1'b1;
                        end else begin
                           next_pc <= pc + `WORD_STEP;
                        end
                        state_r <= S_DONE;
                     end
                     `FMT_IMMEDIATE: begin
                        mem_req <= 1'b1; // see RL12
                        mem_we <= 1'b0;
                        mem_addr <= pc + `WORD_STEP;
                        state_r <= S_IMM;
                     end
                     `FMT_TWO_OP: begin
                        // see RL16: direct mode names the register cell
                        // one-word default; extension paths overwrite next_pc
                        next_pc <= pc + `WORD_STEP; // see RL5
                        src_is_reg <= (in_smode == `MODE_DIRECT);
                        src_ea <= reg_addr(wp, in_sreg);
                        dst_is_reg <= (in_dmode == `MODE_DIRECT);
                        dst_ea <= reg_addr(wp, in_dreg);
                        state_r <= (in_smode == `MODE_DIRECT) ?
                           ((in_dmode == `MODE_DIRECT) ? S_DONE :
                            first_state(in_dmode, in_dreg, 1'b1)) :
                           first_state(in_smode, in_sreg, 1'b0);
                        if (in_smode == `MODE_INDIRECT || in_smode == `MODE_AUTOINC) begin
                           mem_req <= 1'b1;
                           mem_addr <= reg_addr(wp, in_sreg);
                        end else if (in_smode == `MODE_SYMBOLIC) begin
                           mem_req <= 1'b1;
                           mem_addr <= pc + `WORD_STEP;
                        end else if (in_dmode != `MODE_DIRECT) begin
                           mem_req <= 1'b1;
                           mem_addr <= (in_dmode == `MODE_SYMBOLIC) ? pc + `WORD_STEP :
                              reg_addr(wp, in_dreg);
                        end
                        mem_we <= 1'b0;
                     end
                     default: begin
                        next_pc <= pc + `WORD_STEP;
                        state_r <= S_DONE;
                     end
                  endcase
               end
            end
            S_IMM: if (mem_ack) begin
               mem_req <= 1'b0;
               imm_value <= mem_rdata; // see RL12
               imm_valid <= (imm_kind == `IMM_APPLY);
               load_wp <= (imm_kind == `IMM_LOAD_WP);
               load_mask <= (imm_kind == `IMM_LOAD_MASK);
               next_pc <= ipc_r + `WORD_STEP;
               state_r <= S_DONE;
            end
            S_SRC_PTR, S_DST_PTR: if (mem_ack) begin
               // see RL1 RL11: register contents become the address
               if (state_r == S_SRC_PTR) src_ea <= mem_rdata;
               else dst_ea <= mem_rdata;
               ptr_r <= mem_rdata;
               if ((state_r == S_SRC_PTR ? src_mode_field : dest_mode_field) == `MODE_AUTOINC) begin
                  // see RL2 RL19: write back after the old value was captured
                  mem_we <= 1'b1;
                  mem_wdata <= mem_rdata + step;
                  state_r <= (state_r == S_SRC_PTR) ? S_SRC_INC : S_DST_INC;
               end else if (state_r == S_SRC_PTR && after_src != S_DONE) begin
                  mem_addr <= (dest_mode_field == `MODE_SYMBOLIC) ? ipc_r : reg_addr(wp, dest_reg_field);
                  state_r <= after_src;
               end else begin
                  mem_req <= 1'b0;
                  next_pc <= ipc_r;
                  state_r <= S_DONE;
               end
            end
            S_SRC_INC, S_DST_INC: if (mem_ack) begin
               mem_we <= 1'b0;
               if (state_r == S_SRC_INC && after_src != S_DONE) begin
                  mem_addr <= (dest_mode_field == `MODE_SYMBOLIC) ? ipc_r : reg_addr(wp, dest_reg_field);
                  state_r <= after_src;
               end else begin
                  mem_req <= 1'b0;
                  next_pc <= ipc_r;
                  state_r <= S_DONE;
               end
            end
            S_SRC_EXT, S_DST_EXT: if (mem_ack) begin
               // see RL5 RL6: extension words taken in order, source first
               ipc_r <= ipc_r + `WORD_STEP;
               ptr_r <= mem_rdata;
               if ((state_r == S_SRC_EXT ? src_reg_field : dest_reg_field) != `REG_ZERO) begin
                  // see RL7 RL9: nonzero field names the index register
                  mem_addr <= reg_addr(wp, state_r == S_SRC_EXT ? src_reg_field : dest_reg_field);
                  state_r <= (state_r == S_SRC_EXT) ? S_SRC_IDX : S_DST_IDX;
               end else begin
                  if (state_r == S_SRC_EXT) src_ea <= mem_rdata; // see RL4
                  else dst_ea <= mem_rdata;
                  if (state_r == S_SRC_EXT && after_src != S_DONE) begin
                     mem_addr <= (dest_mode_field == `MODE_SYMBOLIC) ? ipc_r + `WORD_STEP :
                        reg_addr(wp, dest_reg_field);
                     state_r <= after_src;
                  end else begin
                     mem_req <= 1'b0;
                     next_pc <= ipc_r + `WORD_STEP;
                     state_r <= S_DONE;
                  end
               end
            end
            S_SRC_IDX, S_DST_IDX: if (mem_ack) begin
               // see RL8 RL10: only the symbolic path reaches this sum
               if (state_r == S_SRC_IDX) src_ea <= ptr_r + mem_rdata;
               else dst_ea <= ptr_r + mem_rdata;
               if (state_r == S_SRC_IDX && after_src != S_DONE) begin
                  mem_addr <= (dest_mode_field == `MODE_SYMBOLIC) ? ipc_r : reg_addr(wp, dest_reg_field);
                  state_r <= after_src;
               end else begin
                  mem_req <= 1'b0;
                  next_pc <= ipc_r;
                  state_r <= S_DONE;
               end
            end
            S_DONE: begin
               // results stand until the next start
               mem_req <= 1'b0;
               busy <= 1'b0;
               done <= 1'b1;
               state_r <= S_IDLE;
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end
endmodule

// file: addr_gen_checker.sv
// checker: handshake, jump and memory-port timing of the address generator
// assumes binding onto operand_address_generator, single clock domain
`timescale 1ns/1ps
module addr_gen_checker (
   input wire clk, input wire rst_n, input wire start, input wire busy, input wire done,
   input wire [2:0] fmt, input wire jump_cond, input wire [15:0] status_word, input wire [15:0] pc,
   input wire [15:0] instr, input wire [15:0] next_pc, input wire jump_taken, input wire mem_req,
   input wire mem_we, input wire [15:0] mem_addr, input wire [15:0] mem_wdata, input wire mem_ack
);
   // ****************
   // sequences
   // ****************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_take; start && !busy; endsequence
   sequence s_jump_take; start && !busy && fmt == 3'h2; endsequence
   sequence s_jump_walk; busy ##1 (done && !busy); endsequence
   // ****************
   // assertions
   // ****************
   a_jump_walk: assert property (s_jump_take |=> s_jump_walk)
      else $error("jump did not finish in two cycles");
   a_jump_always: assert property (s_jump_take ##0 !jump_cond |=> jump_taken)
      else $error("unconditional jump not taken");
   a_jump_equal: assert property (s_jump_take ##0 jump_cond |=> jump_taken == $past(status_word[13]))
      else $error("equal jump decision wrong");
   a_jump_target: assert property (s_jump_take ##0 !jump_cond |=>
      next_pc == $past(pc) + {{7{$past(instr[7])}}, $past(instr[7:0]), 1'b0})
      else $error("jump target wrong");
   a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
      else $error("memory request dropped or changed before ack");
   a_wdata_hold: assert property (mem_req && mem_we && !mem_ack |=> $stable(mem_wdata))
      else $error("write data changed before ack");
   a_start_busy: assert property (s_take |=> busy)
      else $error("start not taken");
   a_done_pulse: assert property (done |=> !done)
      else $error("done longer than one cycle");
   a_done_bound: assert property ($rose(busy) |-> ##[1:80] done)
      else $error("operation did not finish");
   a_idle_quiet: assert property (!busy |-> !mem_req)
      else $error("memory access while idle");
endmodule

// file: mem_model.sv
// memory bus model: word store answering one access per request
// assumes requests held until ack; slow sets the wait cycles
`timescale 1ns/1ps
module mem_model (
   input wire clk,
   input wire [1:0] slow,
   input wire mem_req,
   input wire mem_we,
   input wire [15:0] mem_addr,
   input wire [15:0] mem_wdata,
   output logic mem_ack,
   output logic [15:0] mem_rdata
);
   logic [15:0] m [0:65535];
   logic [1:0] cnt = 2'h0;
   initial begin
      for (int a = 0; a < 65536; a++) m[a] = 16'h0000;
   end
   initial mem_ack = 1'b0;
   initial mem_rdata = 16'h0000;
   // ****************
   // access logic
   // ****************
   always @(posedge clk) begin
      if (mem_ack) begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata; // released bus does not keep the old value
      end else if (mem_req && cnt == slow) begin
         cnt <= 2'h0;
         mem_ack <= 1'b1;
         if (mem_we) m[mem_addr] <= mem_wdata;
         else mem_rdata <= m[mem_addr]; // byte address kept whole
      end else if (mem_req) begin
         cnt <= cnt + 2'h1;
      end
   end
endmodule

// file: testbench.sv
// testbench for the operand address generator
// assumes mem_model on the memory port and the checker bound below
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, jump_cond = 1'b0;
   logic [15:0] instr = 16'h0000, pc = 16'h0100, wp = 16'h0200, status_word = 16'h0000;
   logic [2:0] fmt = 3'h0;
   logic [1:0] imm_kind = 2'h0, slow = 2'h0;
   wire mem_req, mem_we, mem_ack, busy, done, src_is_reg, dst_is_reg, byte_op;
   wire imm_valid, load_wp, load_mask, jump_taken;
   wire [15:0] mem_addr, mem_wdata, mem_rdata, src_ea, dst_ea, imm_value, next_pc;
   int n_errors = 0, num_checks = 0, cyc = 0;
   always #2.5 clk = ~clk;
   operand_address_generator operand_address_generator_inst (.clk(clk), .rst_n(rst_n), .start(start),
      .instr(instr), .fmt(fmt), .imm_kind(imm_kind), .jump_cond(jump_cond), .pc(pc), .wp(wp),
      .status_word(status_word), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy), .done(done),
      .src_is_reg(src_is_reg), .src_ea(src_ea), .dst_is_reg(dst_is_reg), .dst_ea(dst_ea),
      .byte_op(byte_op), .imm_value(imm_value), .imm_valid(imm_valid), .load_wp(load_wp),
      .load_mask(load_mask), .next_pc(next_pc), .jump_taken(jump_taken));
   mem_model mem_model_inst (.clk(clk), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   // ****************
   // shared tasks
   // ****************
   task stop_test;
      if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         stop_test;
      end
   end
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task run(input logic [15:0] i, input logic [2:0] f, input logic [1:0] k, input logic j);
      int t;
      @(posedge clk);
      instr <= i; fmt <= f; imm_kind <= k; jump_cond <= j; start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      t = 0;
      do begin @(negedge clk); t++; end while (done !== 1'b1 && t < 200);
      chk("done", 16'h0001, {15'h0, done});
   endtask
   function automatic logic [15:0] two_op(logic b, logic [1:0] dm, logic [3:0] dr, logic [1:0] sm, logic [3:0] sr);
      return {3'b110, b, dm, dr, sm, sr};
   endfunction
   // ****************
   // scenarios
   // ****************
   task t_autoinc(input logic b);
      mem_model_inst.m[wp + 16'h6] = 16'h1000;
      mem_model_inst.m[wp + 16'h8] = 16'h2000;
      run(two_op(b, 2'b01, 4'h4, 2'b11, 4'h3), 3'h0, 2'h0, 1'b0);
      chk("src_ea", 16'h1000, src_ea);
      chk("dst_ea", 16'h2000, dst_ea);
      chk("byte_op", {15'h0, b}, {15'h0, byte_op});
      chk("inc reg", b ? 16'h1001 : 16'h1002, mem_model_inst.m[wp + 16'h6]);
      chk("plain reg", 16'h2000, mem_model_inst.m[wp + 16'h8]);
      chk("next_pc", pc + 16'h2, next_pc);
   endtask
   task t_dst_inc;
      mem_model_inst.m[wp + 16'h8] = 16'h2000;
      run(two_op(1'b1, 2'b11, 4'h4, 2'b00, 4'h5), 3'h0, 2'h0, 1'b0);
      chk("dst_ea inc", 16'h2000, dst_ea);
      chk("dst inc reg", 16'h2001, mem_model_inst.m[wp + 16'h8]);
      chk("src reg", 16'h0002, {14'h0, src_is_reg, dst_is_reg});
   endtask
   task t_none;
      run(16'h0000, 3'h3, 2'h0, 1'b0);
      chk("none next_pc", pc + 16'h2, next_pc);
      chk("none jump", 16'h0000, {15'h0, jump_taken});
   endtask
   task t_symbolic(input logic [3:0] dr, input logic [15:0] exp_dst);
      mem_model_inst.m[wp] = 16'h1234;
      mem_model_inst.m[wp + 16'h2] = 16'h0004;
      mem_model_inst.m[pc + 16'h2] = 16'hff0a;
      mem_model_inst.m[pc + 16'h4] = 16'hff02;
      run(two_op(1'b0, 2'b10, dr, 2'b10, 4'h0), 3'h0, 2'h0, 1'b0);
      chk("sym src", 16'hff0a, src_ea);
      chk("sym dst", exp_dst, dst_ea);
      chk("sym not reg", 16'h0000, {14'h0, src_is_reg, dst_is_reg});
      chk("sym next_pc", pc + 16'h6, next_pc);
   endtask
   task t_direct;
      run(two_op(1'b0, 2'b00, 4'h2, 2'b00, 4'h5), 3'h0, 2'h0, 1'b0);
      chk("reg flags", 16'h0003, {14'h0, src_is_reg, dst_is_reg});
      chk("src cell", wp + 16'ha, src_ea);
      chk("dst cell", wp + 16'h4, dst_ea);
      chk("direct next_pc", pc + 16'h2, next_pc);
   endtask
   task t_imm;
      mem_model_inst.m[pc + 16'h2] = 16'habcd;
      for (int k = 0; k < 3; k++) begin
         run(16'h0200, 3'h1, k[1:0], 1'b0);
         chk("imm_value", 16'habcd, imm_value);
         chk("imm next_pc", pc + 16'h4, next_pc);
         chk("imm flags", {13'h0, k == 2, k == 1, k == 0}, {13'h0, load_mask, load_wp, imm_valid});
      end
   endtask
   task t_jump(input logic [7:0] d, input logic j, input logic eq, input logic tk);
      @(posedge clk);
      status_word <= {2'b00, eq, 13'h0};
      run({8'h10, d}, 3'h2, 2'h0, j);
      chk("jump_taken", {15'h0, tk}, {15'h0, jump_taken});
      if (tk) chk("next_pc", pc + {{7{d[7]}}, d, 1'b0}, next_pc);
      else chk("next_pc", pc + 16'h2, next_pc);
   endtask
   // ****************
   // main sequence
   // ****************
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_autoinc(1'b0);
      slow <= 2'h3;
      t_autoinc(1'b1);
      t_symbolic(4'h0, 16'hff02);
      slow <= 2'h0;
      t_symbolic(4'h1, 16'hff06);
      t_direct;
      t_dst_inc;
      t_none;
      t_imm;
      t_jump(8'h03, 1'b0, 1'b0, 1'b1);
      t_jump(8'hfe, 1'b0, 1'b0, 1'b1);
      t_jump(8'h02, 1'b1, 1'b1, 1'b1);
      t_jump(8'h02, 1'b1, 1'b0, 1'b0);
      stop_test;
   end
endmodule
bind operand_address_generator addr_gen_checker addr_gen_checker_inst (.clk(clk), .rst_n(rst_n),
   .start(start), .busy(busy), .done(done), .fmt(fmt), .jump_cond(jump_cond), .status_word(status_word),
   .pc(pc), .instr(instr), .next_pc(next_pc), .jump_taken(jump_taken), .mem_req(mem_req), .mem_we(mem_we),
   .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack));
